// ### pcl_pkg.sv
/*
 * Shared constants and types for the octal RAM configuration block.
 * Assumes an 8 ns system clock on both ends of the link.
 */
package pcl_pkg;
  localparam int          MCLK_NS        = 8;
  localparam int          DPD_ENTRY_NS   = 3000;
  localparam int          DPD_ENTRY_CYC  = DPD_ENTRY_NS / MCLK_NS;
  localparam int          REF_GAP_NS     = 2000;
  localparam int          REF_GAP_CYC    = REF_GAP_NS / MCLK_NS;
  localparam int          LINK_HALF      = 5;
  // Latency configuration register fields and reset value.
  localparam int          LAT_DPD_BIT    = 15;
  localparam int          LAT_DRV_HI     = 14;
  localparam int          LAT_DRV_LO     = 12;
  localparam int          LAT_CNT_HI     = 7;
  localparam int          LAT_CNT_LO     = 4;
  localparam int          LAT_FIX_BIT    = 3;
  localparam logic [15:0] LAT_RESET      = 16'h8078;
  localparam logic [3:0]  LAT_MIN        = 4'h3;
  localparam logic [3:0]  LAT_MAX        = 4'h7;
  // Refresh configuration register fields and reset value.
  localparam int          RCF_BURST_BIT  = 7;
  localparam int          RCF_CLK_BIT    = 6;
  localparam int          RCF_HS_BIT     = 5;
  localparam int          RCF_PAR_HI     = 4;
  localparam int          RCF_PAR_LO     = 2;
  localparam logic [15:0] RCF_RESET      = 16'hFFC0;
  localparam logic [7:0]  RCF_RSVD       = 8'hFF;
  localparam logic [2:0]  PAR_NONE       = 3'h4;
  localparam logic [1:0]  CSM_4US        = 2'h1;
  localparam logic [1:0]  CSM_1US        = 2'h2;
  // Register space addresses on the link.
  localparam logic [15:0] REG_ADDR_LAT   = 16'h0000;
  localparam logic [15:0] REG_ADDR_RCF   = 16'h0001;
  // Command byte and framing.
  localparam int          CMD_RD_BIT     = 7;
  localparam int          CMD_REG_BIT    = 6;
  localparam logic [4:0]  CA_BYTES       = 5'h3;
  localparam logic [4:0]  DATA_BYTES     = 5'h2;
  // Host controller register map.
  localparam logic [3:0]  H_CMD          = 4'h0;
  localparam logic [3:0]  H_ADDR         = 4'h1;
  localparam logic [3:0]  H_WDATA        = 4'h2;
  localparam logic [3:0]  H_STATUS       = 4'h3;
  localparam logic [3:0]  H_RDATA        = 4'h4;
  localparam logic [3:0]  H_LAT          = 4'h5;
  localparam logic [3:0]  H_PIN          = 4'h6;
  localparam int          HC_GO          = 0;
  localparam int          HC_RD          = 1;
  localparam int          HC_REG         = 2;
  localparam int          HC_WAKE        = 3;

  typedef enum {D_IDLE, D_CA, D_LAT, D_DATA, D_DONE, D_DPD, D_DPD_LOW} pcl_dev_st_t;
  typedef enum {H_IDLE, H_RUN, H_END, H_WAKE} pcl_host_st_t;
endpackage

// ### pcl_link_if.sv
/*
 * Pins between host controller and memory device.
 * Assumes a pull-up on the shared data and strobe lines.
 */
`timescale 1ns/1ps
`default_nettype none
interface pcl_link_if;
  logic       cs_n;
  logic       link_clk;
  logic       clk_cmp;
  logic       hw_rst_n;
  logic [7:0] dq_h_o;
  logic       dq_h_oe;
  logic [7:0] dq_d_o;
  logic       dq_d_oe;
  logic       read_write_strobe_h_o;
  logic       read_write_strobe_h_oe;
  logic       read_write_strobe_d_o;
  logic       read_write_strobe_d_oe;
  logic [7:0] dq;
  logic       read_write_strobe;

  assign dq   = dq_d_oe ? dq_d_o : (dq_h_oe ? dq_h_o : 8'hFF);
  assign read_write_strobe = read_write_strobe_d_oe ? read_write_strobe_d_o : (read_write_strobe_h_oe ? read_write_strobe_h_o : 1'b1);

  modport dev (input cs_n, link_clk, clk_cmp, hw_rst_n, dq, read_write_strobe,
               output dq_d_o, dq_d_oe, read_write_strobe_d_o, read_write_strobe_d_oe);
  modport host (output cs_n, link_clk, clk_cmp, hw_rst_n, dq_h_o, dq_h_oe,
                read_write_strobe_h_o, read_write_strobe_h_oe, input dq, read_write_strobe);
endinterface
`default_nettype wire

// ### pcl_sync.sv
/*
 * Two flip-flop synchroniser for a bundle of pin inputs.
 * Assumes each bit is an independent level.
 * Both stages reset to the idle level of each pin, so no false edge follows reset.
 */
`timescale 1ns/1ps
`default_nettype none
module pcl_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         mclk_i,
  input  wire logic         nrst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pcl_sync_t;
  pcl_sync_t r_reg;
  pcl_sync_t r_next;

  always_comb begin
    r_next.s1 = d_i;
    r_next.s2 = r_reg.s1;
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r_reg <= '{s1: RST, s2: RST};
    end else begin
      r_reg <= r_next;
    end
  end

  assign q_o = r_reg.s2;
endmodule
`default_nettype wire

// ### pcl_device.sv
/*
 * Memory device end: configuration registers, latency, refresh, power states.
 * Assumes the host makes the link clock and changes data on its falling edge.
 */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Latency 3 to 7 clocks from bits 7:4
// - Latency resets to seven clocks
// - Pending refresh raises strobe, adds latency
// - Register writes take data right after address
// - Refresh runs beside register write capture
// - Fixed latency bit forces doubled latency
// - Fixed latency selected after any reset
// - Bits 14:12 select drive impedance, reset zero
// - Clearing bit 15 enters deep power down
// - Array contents lost after deep power down
// - Select pulse or reset leaves power down
// - Power down ignores all but select, reset
// - Host writes all ones to upper byte
// - Bit 7 selects linear or wrapped burst
// - Bit 6 selects single or differential clock
// - Single clock mode ignores complement input
// - Host never leaves complement input floating
// - Bit 5 set enters hybrid sleep
// - Bits 4:2 choose refreshed array region
// - Self refresh stays inside chosen region
// - Bits 1:0 report maximum select low time
// - Latency covers row open for all accesses but register writes
// - High strobe doubles programmed latency
// - Falling select ends hybrid sleep, clears bit
module pcl_device #(
  parameter int         MEM_AW   = 8,
  parameter int         ROW_W    = 3,
  parameter int         DPD_CYC  = pcl_pkg::DPD_ENTRY_CYC,
  parameter int         REF_CYC  = pcl_pkg::REF_GAP_CYC,
  parameter logic [1:0] CSM_CODE = pcl_pkg::CSM_4US
) (
  input  wire logic             mclk_i,
  input  wire logic             nrst_i,
  pcl_link_if.dev               link,
  output logic      [2:0]       drive_strength_o,
  output logic                  dpd_o,
  output logic                  hybrid_sleep_o,
  output logic                  burst_linear_o,
  output logic                  clk_single_o,
  output logic      [ROW_W-1:0] refresh_row_o,
  output logic                  refresh_strobe_o,
  output logic                  array_lost_o,
  output logic                  busy_o
);
  localparam logic [ROW_W:0] ROWS = (ROW_W+1)'(1 << ROW_W);

  typedef struct packed {
    pcl_pkg::pcl_dev_st_t st;
    logic [15:0]          lat_cfg;
    logic [15:0]          rcf;
    logic                 clk_prev;
    logic [1:0]           cnt;
    logic [4:0]           lat_left;
    logic                 dbl;
    logic [7:0]           cmd;
    logic [15:0]          addr;
    logic [7:0]           wbuf;
    logic [7:0]           dq_o;
    logic                 dq_oe;
    logic                 read_write_strobe_o;
    logic                 read_write_strobe_oe;
    logic                 ref_pend;
    logic [15:0]          ref_timer;
    logic [ROW_W-1:0]     ref_row;
    logic                 ref_strobe;
    logic [15:0]          dpd_left;
    logic                 lost;
    logic                 mem_we;
    logic [MEM_AW-1:0]    mem_wa;
    logic [7:0]           mem_wd;
    logic                 deep_power_down;
    logic                 busy;
  } pcl_dev_t;

  localparam pcl_dev_t DEV_RST = '{st: pcl_pkg::D_IDLE, lat_cfg: pcl_pkg::LAT_RESET,
                                   rcf: pcl_pkg::RCF_RESET, default: '0};

  pcl_dev_t   r_reg;
  pcl_dev_t   r_next;
  logic [7:0] mem [2**MEM_AW];
  logic [12:0] pins_s;
  logic       hw_rst_s, cs_s, clk_s, cmp_s, read_write_strobe_s;
  logic [7:0] dq_s;

  // Sync stages idle at the pin levels: select, reset and complement high, pulled-up bus high.
  pcl_sync #(.W(13), .RST({1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 8'hFF})) u_sync (
    .mclk_i (mclk_i),
    .nrst_i (nrst_i),
    .d_i    ({link.hw_rst_n, link.cs_n, link.link_clk, link.clk_cmp, link.read_write_strobe, link.dq}),
    .q_o    (pins_s)
  );
  assign {hw_rst_s, cs_s, clk_s, cmp_s, read_write_strobe_s, dq_s} = pins_s;

  always_comb begin
    logic              eff_clk, rise, is_rd, is_reg, ref_go;
    logic [3:0]        lat;
    logic [2:0]        par;
    logic [ROW_W:0]    size, lo, hi, row;
    logic [15:0]       rd_word;
    logic [MEM_AW-1:0] a0;
    logic [7:0]        b0, b1;
    r_next = r_reg;
    r_next.ref_strobe = 1'b0;
    r_next.mem_we = 1'b0;
    eff_clk = r_reg.rcf[pcl_pkg::RCF_CLK_BIT] ? clk_s : (clk_s & ~cmp_s);
    rise = eff_clk & ~r_reg.clk_prev;
    r_next.clk_prev = eff_clk;
    lat = r_reg.lat_cfg[pcl_pkg::LAT_CNT_HI:pcl_pkg::LAT_CNT_LO];
    if (lat < pcl_pkg::LAT_MIN) lat = pcl_pkg::LAT_MIN;
    if (lat > pcl_pkg::LAT_MAX) lat = pcl_pkg::LAT_MAX;
    is_rd  = r_reg.cmd[pcl_pkg::CMD_RD_BIT];
    is_reg = r_reg.cmd[pcl_pkg::CMD_REG_BIT];
    rd_word = (r_reg.addr == pcl_pkg::REG_ADDR_LAT) ? r_reg.lat_cfg :
              {r_reg.rcf[15:2], CSM_CODE};
    a0 = r_reg.addr[MEM_AW-1:0];
    b0 = is_reg ? rd_word[15:8] : mem[a0];
    b1 = is_reg ? rd_word[7:0] : mem[a0 + MEM_AW'(1)];
    par  = r_reg.rcf[pcl_pkg::RCF_PAR_HI:pcl_pkg::RCF_PAR_LO];
    size = ROWS >> par[1:0];
    lo   = par[2] ? ROWS - size : '0;
    hi   = lo + size - (ROW_W+1)'(1);
    row  = {1'b0, r_reg.ref_row};
    if (row < lo || row > hi) row = lo;
    ref_go = r_reg.ref_pend & ((r_reg.st == pcl_pkg::D_IDLE) ||
             (r_reg.st == pcl_pkg::D_DATA && is_reg && !is_rd) ||
             (r_reg.st == pcl_pkg::D_LAT && r_reg.dbl));
    if (ref_go) begin
      r_next.ref_pend = 1'b0;
      r_next.ref_strobe = 1'b1;
      r_next.ref_row = (row == hi) ? lo[ROW_W-1:0] : row[ROW_W-1:0] + ROW_W'(1);
    end
    // The timer follows the grant, so a new request in the grant cycle is not lost.
    // refresh stops in power down
    if (r_reg.st != pcl_pkg::D_DPD && r_reg.st != pcl_pkg::D_DPD_LOW &&
        par != pcl_pkg::PAR_NONE) begin
      if (r_reg.ref_timer == '0) begin
        r_next.ref_timer = 16'(REF_CYC - 1);
        r_next.ref_pend = 1'b1;
      end else begin
        r_next.ref_timer = r_reg.ref_timer - 16'h0001;
      end
    end
    unique case (r_reg.st)
      pcl_pkg::D_IDLE: begin
        if (!cs_s) begin
          r_next.st = pcl_pkg::D_CA;
          r_next.cnt = 2'h0;
          r_next.read_write_strobe_oe = 1'b1;
          r_next.read_write_strobe_o = r_reg.lat_cfg[pcl_pkg::LAT_FIX_BIT] | r_reg.ref_pend;
          r_next.dbl = r_reg.lat_cfg[pcl_pkg::LAT_FIX_BIT] | r_reg.ref_pend;
          r_next.rcf[pcl_pkg::RCF_HS_BIT] = 1'b0;
        end
      end
      pcl_pkg::D_CA: begin
        if (rise) begin
          r_next.cnt = r_reg.cnt + 2'h1;
          if (r_reg.cnt == 2'h0) r_next.cmd = dq_s;
          if (r_reg.cnt == 2'h1) r_next.addr[15:8] = dq_s;
          if (r_reg.cnt == 2'h2) begin
            r_next.addr[7:0] = dq_s;
            r_next.cnt = 2'h0;
            if (is_reg && !is_rd) begin
              r_next.st = pcl_pkg::D_DATA;
              r_next.read_write_strobe_oe = 1'b0;
            end else begin
              r_next.st = pcl_pkg::D_LAT;
              r_next.lat_left = r_reg.dbl ? {lat, 1'b0} : {1'b0, lat};
              r_next.read_write_strobe_o = 1'b0;
              r_next.read_write_strobe_oe = is_rd;
            end
          end
        end
      end
      pcl_pkg::D_LAT: begin
        if (rise) begin
          r_next.lat_left = r_reg.lat_left - 5'h01;
          if (r_reg.lat_left == 5'h01) begin
            r_next.st = pcl_pkg::D_DATA;
            if (is_rd) begin
              r_next.dq_o = b0;
              r_next.dq_oe = 1'b1;
              r_next.read_write_strobe_o = 1'b1;
            end
          end
        end
      end
      pcl_pkg::D_DATA: begin
        if (rise) begin
          r_next.cnt = r_reg.cnt + 2'h1;
          if (is_rd) begin
            r_next.dq_o = b1;
            r_next.read_write_strobe_o = 1'b0;
          end else if (is_reg) begin
            r_next.wbuf = dq_s;
          end else begin
            r_next.mem_we = ~read_write_strobe_s;
            r_next.mem_wa = a0 + MEM_AW'(r_reg.cnt);
            r_next.mem_wd = dq_s;
          end
          if (r_reg.cnt == 2'h1) begin
            r_next.st = pcl_pkg::D_DONE;
            r_next.dq_oe = 1'b0;
            r_next.read_write_strobe_oe = 1'b0;
            if (is_reg && !is_rd) begin
              if (r_reg.addr == pcl_pkg::REG_ADDR_LAT) begin
                r_next.lat_cfg = {r_reg.wbuf, dq_s};
                if (!r_reg.wbuf[pcl_pkg::LAT_DPD_BIT - 8]) r_next.dpd_left = 16'(DPD_CYC);
              end else if (r_reg.addr == pcl_pkg::REG_ADDR_RCF) begin
                r_next.rcf = {r_reg.wbuf, dq_s[7:2], 2'h0};
              end
            end
          end
        end
      end
      pcl_pkg::D_DONE: begin
      end
      pcl_pkg::D_DPD: begin
        if (!cs_s) r_next.st = pcl_pkg::D_DPD_LOW;
      end
      pcl_pkg::D_DPD_LOW: begin
        if (cs_s) begin
          r_next.st = pcl_pkg::D_IDLE;
          r_next.lat_cfg[pcl_pkg::LAT_DPD_BIT] = 1'b1;
        end
      end
    endcase
    if (cs_s && r_reg.st != pcl_pkg::D_IDLE && r_reg.st != pcl_pkg::D_DPD &&
        r_reg.st != pcl_pkg::D_DPD_LOW) begin
      r_next.st = pcl_pkg::D_IDLE;
      r_next.dq_oe = 1'b0;
      r_next.read_write_strobe_oe = 1'b0;
    end
    if (r_reg.dpd_left != '0) begin
      r_next.dpd_left = r_reg.dpd_left - 16'h0001;
      if (r_reg.dpd_left == 16'h0001) begin
        r_next.st = pcl_pkg::D_DPD;
        r_next.lost = 1'b1;
        r_next.ref_pend = 1'b0;
        r_next.dq_oe = 1'b0;
        r_next.read_write_strobe_oe = 1'b0;
      end
    end
    if (!hw_rst_s) r_next = DEV_RST;
    r_next.deep_power_down  = (r_next.st == pcl_pkg::D_DPD) || (r_next.st == pcl_pkg::D_DPD_LOW);
    r_next.busy = (r_next.st != pcl_pkg::D_IDLE);
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r_reg <= DEV_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (r_reg.mem_we) begin
      mem[r_reg.mem_wa] <= r_reg.mem_wd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign link.dq_d_o      = r_reg.dq_o;
  assign link.dq_d_oe     = r_reg.dq_oe;
  assign link.read_write_strobe_d_o    = r_reg.read_write_strobe_o;
  assign link.read_write_strobe_d_oe   = r_reg.read_write_strobe_oe;
  assign drive_strength_o = r_reg.lat_cfg[pcl_pkg::LAT_DRV_HI:pcl_pkg::LAT_DRV_LO];
  assign dpd_o            = r_reg.deep_power_down;
  assign hybrid_sleep_o   = r_reg.rcf[pcl_pkg::RCF_HS_BIT];
  assign burst_linear_o   = r_reg.rcf[pcl_pkg::RCF_BURST_BIT];
  assign clk_single_o     = r_reg.rcf[pcl_pkg::RCF_CLK_BIT];
  assign refresh_row_o    = r_reg.ref_row;
  assign refresh_strobe_o = r_reg.ref_strobe;
  assign array_lost_o     = r_reg.lost;
  assign busy_o           = r_reg.busy;
endmodule
`default_nettype wire

// ### pcl_host.sv
/*
 * Host controller end: makes the link clock, frames accesses, reads strobe.
 * Assumes software programs the host latency register to match the device.
 */
`timescale 1ns/1ps
`default_nettype none
module pcl_host #(
  parameter int HALF = pcl_pkg::LINK_HALF
) (
  input  wire logic        mclk_i,
  input  wire logic        nrst_i,
  pcl_link_if.host         link,
  input  wire logic [3:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  output logic             busy_o
);
  typedef struct packed {
    pcl_pkg::pcl_host_st_t st;
    logic [7:0]            div;
    logic                  clk;
    logic                  cs_n;
    logic [7:0]            dq_o;
    logic                  dq_oe;
    logic                  read_write_strobe_oe;
    logic [4:0]            rises;
    logic [4:0]            lat_n;
    logic                  rd;
    logic                  rg;
    logic [15:0]           addr;
    logic [15:0]           wdata;
    logic [15:0]           rdata;
    logic                  dbl;
    logic [3:0]            lat;
    logic                  rst_pin;
    logic [15:0]           bus_rdata;
    logic                  busy;
  } pcl_host_t;

  localparam pcl_host_t HOST_RST = '{st: pcl_pkg::H_IDLE, cs_n: 1'b1, rst_pin: 1'b1,
                                     lat: pcl_pkg::LAT_MAX, default: '0};

  pcl_host_t  r_reg;
  pcl_host_t  r_next;
  logic [8:0] pins_s;
  logic       read_write_strobe_s;
  logic [7:0] dq_s;

  // Sync stages idle at the pulled-up bus level.
  pcl_sync #(.W(9), .RST(9'h1FF)) u_sync (
    .mclk_i (mclk_i),
    .nrst_i (nrst_i),
    .d_i    ({link.read_write_strobe, link.dq}),
    .q_o    (pins_s)
  );
  assign {read_write_strobe_s, dq_s} = pins_s;

  always_comb begin
    logic       tick;
    logic [4:0] idx, dstart;
    r_next = r_reg;
    tick = (r_reg.div == 8'(HALF - 1));
    r_next.div = tick ? 8'h00 : r_reg.div + 8'h01;
    dstart = pcl_pkg::CA_BYTES + r_reg.lat_n;
    idx = r_reg.rises;
    if (rd_i) begin
      unique case (addr_i)
        pcl_pkg::H_ADDR:   r_next.bus_rdata = r_reg.addr;
        pcl_pkg::H_WDATA:  r_next.bus_rdata = r_reg.wdata;
        pcl_pkg::H_STATUS: r_next.bus_rdata = {13'h0, r_reg.rst_pin, r_reg.dbl,
                                               r_reg.st != pcl_pkg::H_IDLE};
        pcl_pkg::H_RDATA:  r_next.bus_rdata = r_reg.rdata;
        pcl_pkg::H_LAT:    r_next.bus_rdata = {12'h0, r_reg.lat};
        pcl_pkg::H_PIN:    r_next.bus_rdata = {15'h0, r_reg.rst_pin};
        default:           r_next.bus_rdata = '0;
      endcase
    end
    if (wr_i) begin
      if (addr_i == pcl_pkg::H_ADDR) r_next.addr = wdata_i;
      if (addr_i == pcl_pkg::H_WDATA) r_next.wdata = wdata_i;
      if (addr_i == pcl_pkg::H_LAT) r_next.lat = wdata_i[3:0];
      if (addr_i == pcl_pkg::H_PIN) r_next.rst_pin = wdata_i[0];
    end
    unique case (r_reg.st)
      pcl_pkg::H_IDLE: begin
        r_next.div = 8'h00;
        if (wr_i && addr_i == pcl_pkg::H_CMD && wdata_i[pcl_pkg::HC_WAKE]) begin
          r_next.st = pcl_pkg::H_WAKE;
          r_next.cs_n = 1'b0;
          r_next.rises = '0;
        end else if (wr_i && addr_i == pcl_pkg::H_CMD && wdata_i[pcl_pkg::HC_GO]) begin
          r_next.st = pcl_pkg::H_RUN;
          r_next.cs_n = 1'b0;
          r_next.rd = wdata_i[pcl_pkg::HC_RD];
          r_next.rg = wdata_i[pcl_pkg::HC_REG];
          r_next.rises = '0;
          r_next.lat_n = '0;
          r_next.dq_o = '0;
          r_next.dq_o[pcl_pkg::CMD_RD_BIT] = wdata_i[pcl_pkg::HC_RD];
          r_next.dq_o[pcl_pkg::CMD_REG_BIT] = wdata_i[pcl_pkg::HC_REG];
          r_next.dq_oe = 1'b1;
          if (wdata_i[pcl_pkg::HC_REG] && r_reg.addr == pcl_pkg::REG_ADDR_RCF)
            r_next.wdata[15:8] = pcl_pkg::RCF_RSVD;
        end
      end
      pcl_pkg::H_RUN: begin
        if (tick && !r_reg.clk) begin
          r_next.clk = 1'b1;
          r_next.rises = r_reg.rises + 5'h01;
          if (r_reg.rises == pcl_pkg::CA_BYTES - 5'h01) begin
            r_next.dbl = read_write_strobe_s;
            r_next.lat_n = (r_reg.rg && !r_reg.rd) ? 5'h00 :
                           (read_write_strobe_s ? {r_reg.lat, 1'b0} : {1'b0, r_reg.lat});
          end
          if (r_reg.rd && r_reg.rises >= dstart) r_next.rdata = {r_reg.rdata[7:0], dq_s};
        end else if (tick) begin
          r_next.clk = 1'b0;
          if (r_reg.rises == dstart + pcl_pkg::DATA_BYTES) begin
            r_next.st = pcl_pkg::H_END;
            r_next.cs_n = 1'b1;
            r_next.rises = '0;
            r_next.dq_oe = 1'b0;
            r_next.read_write_strobe_oe = 1'b0;
          end else if (idx == 5'h01) begin
            r_next.dq_o = r_reg.addr[15:8];
          end else if (idx == 5'h02) begin
            r_next.dq_o = r_reg.addr[7:0];
          end else if (!r_reg.rd && idx >= dstart) begin
            r_next.dq_o = (idx == dstart) ? r_reg.wdata[15:8] : r_reg.wdata[7:0];
            r_next.dq_oe = 1'b1;
            r_next.read_write_strobe_oe = ~r_reg.rg;
          end else begin
            r_next.dq_oe = 1'b0;
          end
        end
      end
      pcl_pkg::H_WAKE, pcl_pkg::H_END: begin
        if (tick) begin
          r_next.rises = r_reg.rises + 5'h01;
          if (r_reg.rises == 5'h01) begin
            r_next.rises = '0;
            r_next.st = (r_reg.st == pcl_pkg::H_WAKE) ? pcl_pkg::H_END : pcl_pkg::H_IDLE;
            r_next.cs_n = 1'b1;
          end
        end
      end
    endcase
    r_next.busy = (r_next.st != pcl_pkg::H_IDLE);
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r_reg <= HOST_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The complement clock is always driven so it never floats.
  assign link.cs_n      = r_reg.cs_n;
  assign link.link_clk  = r_reg.clk;
  assign link.clk_cmp   = ~r_reg.clk;
  assign link.hw_rst_n  = r_reg.rst_pin;
  assign link.dq_h_o    = r_reg.dq_o;
  assign link.dq_h_oe   = r_reg.dq_oe;
  assign link.read_write_strobe_h_o  = 1'b0;
  assign link.read_write_strobe_h_oe = r_reg.read_write_strobe_oe;
  assign rdata_o        = r_reg.bus_rdata;
  assign busy_o         = r_reg.busy;
endmodule
`default_nettype wire

// ### pcl_link_monitor.sv
/* Checker for the link between host and device ends.
   Takes the interface signals as plain inputs; 8 ns clock. */
`timescale 1ns/1ps
`default_nettype none
module pcl_link_monitor (
  input wire logic       mclk_i,
  input wire logic       nrst_i,
  input wire logic       cs_n,
  input wire logic       link_clk,
  input wire logic       clk_cmp,
  input wire logic       hw_rst_n,
  input wire logic       dq_h_oe,
  input wire logic       dq_d_oe,
  input wire logic [7:0] dq_d_o,
  input wire logic       read_write_strobe_h_oe,
  input wire logic       read_write_strobe_d_oe,
  input wire logic       read_write_strobe_d_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  property p_idle_dq; cs_n [*6] |-> !dq_d_oe; endproperty
  a_idle_dq: assert property (p_idle_dq) else $error("data driven while idle");
  property p_idle_read_write_strobe; cs_n [*6] |-> !read_write_strobe_d_oe; endproperty
  a_idle_read_write_strobe: assert property (p_idle_read_write_strobe) else $error("strobe driven while idle");
  property p_cmp; clk_cmp == !link_clk; endproperty
  a_cmp: assert property (p_cmp) else $error("complement clock wrong");
  property p_clk_idle; cs_n [*3] |-> !link_clk; endproperty
  a_clk_idle: assert property (p_clk_idle) else $error("clock runs outside frame");
  property p_dq_step; dq_d_oe && $past(dq_d_oe) && dq_d_o != $past(dq_d_o) |-> link_clk; endproperty
  a_dq_step: assert property (p_dq_step) else $error("read data moved late");
  property p_dq_fight; !(dq_d_oe && dq_h_oe); endproperty
  a_dq_fight: assert property (p_dq_fight) else $error("data contention");
  property p_read_write_strobe_fight; !(read_write_strobe_d_oe && read_write_strobe_h_oe); endproperty
  a_read_write_strobe_fight: assert property (p_read_write_strobe_fight) else $error("strobe contention");
  property p_pin_rst; !hw_rst_n [*4] |-> !dq_d_oe && !read_write_strobe_d_oe; endproperty
  a_pin_rst: assert property (p_pin_rst) else $error("drive during pin reset");
  c_read: cover property (dq_d_oe);
  c_dbl: cover property (read_write_strobe_d_oe && read_write_strobe_d_o && !dq_d_oe);
  c_pin: cover property (!hw_rst_n);
endmodule
`default_nettype wire

// ### testbench.sv
/* Bench joining host and device ends through the link interface.
   Drives the host register port only; no far-side model. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        mclk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [3:0]  addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [15:0] rdata_o;
  logic [15:0] v;
  logic        busy_o, dpd_o, hyb_o, lin_o, sgl_o, lost_o;
  logic [2:0]  drv_o, ref_row;
  logic        ref_stb, dbusy;
  int          w;
  int          n_fail = 0;
  int          total_checks = 0;
  pcl_link_if link_if ();
  pcl_host pcl_host_inst (.mclk_i(mclk_i), .nrst_i(nrst_i), .link(link_if.host),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .busy_o(busy_o));
  pcl_device #(.DPD_CYC(20), .REF_CYC(40)) pcl_device_inst (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .link(link_if.dev), .drive_strength_o(drv_o), .dpd_o(dpd_o), .hybrid_sleep_o(hyb_o),
    .burst_linear_o(lin_o), .clk_single_o(sgl_o), .refresh_row_o(ref_row),
    .refresh_strobe_o(ref_stb), .array_lost_o(lost_o), .busy_o(dbusy));
  pcl_link_monitor pcl_link_monitor_inst (.mclk_i(mclk_i), .nrst_i(nrst_i), .cs_n(link_if.cs_n),
    .link_clk(link_if.link_clk), .clk_cmp(link_if.clk_cmp), .hw_rst_n(link_if.hw_rst_n),
    .dq_h_oe(link_if.dq_h_oe), .dq_d_oe(link_if.dq_d_oe), .dq_d_o(link_if.dq_d_o),
    .read_write_strobe_h_oe(link_if.read_write_strobe_h_oe), .read_write_strobe_d_oe(link_if.read_write_strobe_d_oe), .read_write_strobe_d_o(link_if.read_write_strobe_d_o));
  always #4 mclk_i = ~mclk_i;
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %0s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  // Runs one link frame and waits, bounded, for the host to finish it.
  task automatic acc(input logic [3:0] c, input logic [15:0] a, input logic [15:0] d);
    int i;
    wr(4'h1, a);
    wr(4'h2, d);
    wr(4'h0, {12'h000, c});
    @(posedge mclk_i);
    for (i = 0; i < 3000 && busy_o !== 1'b0; i++) @(posedge mclk_i);
    if (i == 3000) begin
      n_fail++;
      conclude();
    end
  endtask
  task automatic rdr(input logic [3:0] c, input logic [15:0] a, input logic [15:0] e, input string n);
    acc(c, a, 16'h0000);
    rd(4'h4);
    chk(n, v, e);
  endtask
  initial begin
    repeat (12) @(posedge mclk_i);
    nrst_i <= 1'b1;
    @(posedge mclk_i);
    chk("drive", 16'(drv_o), 16'h0000);
    chk("linear", 16'(lin_o), 16'h0001);
    chk("single", 16'(sgl_o), 16'h0001);
    rdr(4'h7, 16'h0000, 16'h8078, "lat");
    rd(4'h3);
    chk("double", v & 16'h0002, 16'h0002);
    rdr(4'h7, 16'h0001, 16'hFFC1, "rcf");
    rd(4'hF);
    chk("unmapped", v, 16'h0000);
    $display("test reset done");
    wr(4'h5, 16'h0003);
    acc(4'h5, 16'h0000, 16'hF030);
    chk("drive", 16'(drv_o), 16'h0007);
    rdr(4'h7, 16'h0000, 16'hF030, "lat3");
    acc(4'h1, 16'h0010, 16'hA55A);
    rdr(4'h3, 16'h0010, 16'hA55A, "mem");
    for (int k = 0; k < 8; k++) begin
      acc(4'h5, 16'h0001, 16'hFF40 | (16'(k) << 2));
      rdr(4'h7, 16'h0001, 16'hFF41 | (16'(k) << 2), "region");
      for (w = 0; w < 100 && ref_stb !== 1'b1; w++) @(posedge mclk_i);
      chk("refresh", 16'(ref_stb), 16'(k != 4));
      if (k % 4 != 0) chk("half", 16'(ref_row[2]), 16'(k / 4));
      if (k % 4 == 3) chk("eighth", 16'(ref_row), 16'(k == 7 ? 7 : 0));
    end
    chk("linear", 16'(lin_o), 16'h0000);
    acc(4'h5, 16'h0001, 16'hFF80);
    chk("single", 16'(sgl_o), 16'h0000);
    rdr(4'h3, 16'h0010, 16'hA55A, "diff");
    $display("test config done");
    acc(4'h5, 16'h0001, 16'hFFE0);
    chk("sleep", 16'(hyb_o), 16'h0001);
    rdr(4'h3, 16'h0010, 16'hA55A, "sleepmem");
    chk("sleep", 16'(hyb_o), 16'h0000);
    acc(4'h5, 16'h0000, 16'h7030);
    repeat (40) @(posedge mclk_i);
    chk("dpd", 16'(dpd_o), 16'h0001);
    chk("lost", 16'(lost_o), 16'h0001);
    acc(4'h8, 16'h0000, 16'h0000);
    chk("dpd", 16'(dpd_o), 16'h0000);
    chk("devbusy", 16'(dbusy), 16'h0000);
    rdr(4'h7, 16'h0000, 16'hF030, "wake");
    wr(4'h6, 16'h0000);
    repeat (10) @(posedge mclk_i);
    wr(4'h6, 16'h0001);
    wr(4'h5, 16'h0007);
    rdr(4'h7, 16'h0000, 16'h8078, "pinrst");
    $display("test power done");
    conclude();
  end
endmodule
`default_nettype wire
